/* core/nfc_pkg.sv */
// Shared constants, field layouts, carriers and state codes of the flash control block
package nfc_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int unsigned NFC_ADDR_W      = 8;                  // Decoded address bits
   localparam logic [7:0]  NFC_CTRL_OFS    = 8'h00;              // Control register offset
   localparam logic [7:0]  NFC_STAT_OFS    = 8'h04;              // Status register offset
   localparam logic [15:0] NFC_CTRL_RST    = 16'h0000;           // Control reset value
   localparam logic [31:0] NFC_RD_ZERO     = 32'h0000_0000;      // Unmapped read answer

   // ************************************************************
   // Control field positions
   // ************************************************************
   localparam int unsigned NFC_IRQ_CLR_BIT = 14;                 // Write one clears request
   localparam int unsigned NFC_IRQ_EN_BIT  = 13;                 // Interrupt enable
   localparam int unsigned NFC_PROG_EN_BIT = 12;                 // Program enable
   localparam int unsigned NFC_ERS_GO_BIT  = 11;                 // Erase start, write one
   localparam int unsigned NFC_ERS_EN_BIT  = 10;                 // Erase enable
   localparam int unsigned NFC_DIS_BIT     = 9;                  // Flash disable
   localparam int unsigned NFC_STBY_BIT    = 8;                  // Standby select
   localparam int unsigned NFC_PROT_BIT    = 7;                  // Protected bank

   // ************************************************************
   // Status field positions
   // ************************************************************
   localparam int unsigned NFC_ST_IRQ_BIT  = 0;                  // Request pending
   localparam int unsigned NFC_ST_DONE_BIT = 1;                  // Synced completion flag
   localparam int unsigned NFC_ST_BUSY_BIT = 2;                  // Erase in progress
   localparam int unsigned NFC_ST_EREF_BIT = 3;                  // Last erase start refused
   localparam int unsigned NFC_ST_PREF_BIT = 4;                  // A program was refused

   // ************************************************************
   // Bus constants
   // ************************************************************
   localparam logic [2:0]  NFC_HSIZE_WORD  = 3'h2;               // Whole word transfer
   localparam logic [1:0]  NFC_HRESP_OKAY  = 2'h0;               // Always OKAY

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic                  wr;      // Write data phase pulse
      logic                  rd;      // Read capture pulse
      logic [NFC_ADDR_W-1:0] addr;    // Word aligned offset
      logic [31:0]           wdata;   // Write data
   } nfc_regreq_t;

   typedef struct packed {
      logic irq_enable;              // Interrupt enable
      logic program_enable;          // Program enable
      logic erase_enable;            // Erase enable
      logic flash_disable;           // Flash disable
      logic standby_select;          // Standby select
      logic protected_sector_bank;   // Bank protect
   } nfc_ctrl_t;

   typedef struct packed {
      logic program_allow;   // Programming permitted
      logic erase_go;        // One-cycle erase start
      logic pins_oe;         // Flash outputs driven
      logic standby;         // Low power standby
      logic irq;             // Interrupt request
   } nfc_flash_out_t;

   // ************************************************************
   // State codes
   // ************************************************************
   typedef enum logic [3:0] {
      NFC_BUS_IDLE = 4'b0001,   // No transfer
      NFC_BUS_WR   = 4'b0010,   // Write data phase
      NFC_BUS_RDW  = 4'b0100,   // Read wait cycle
      NFC_BUS_RDD  = 4'b1000    // Read data phase
   } nfc_bus_st_t;

   typedef enum logic [1:0] {
      NFC_ERS_IDLE = 2'b01,   // No erase running
      NFC_ERS_RUN  = 2'b10    // Erase running
   } nfc_ers_st_t;

endpackage

/* core/nfc_sync_rise.sv */
// Two-stage synchroniser with rising edge detect for an outside level
module nfc_sync_rise
   import nfc_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic meta;   // First stage, read by sync only
      logic sync;   // Second stage
      logic prev;   // Previous synced value
   } nfc_sr_state_t;

   nfc_sr_state_t state_ff;                                      // Registered state
   nfc_sr_state_t nxt_state;                                     // Next state

   // Shift the level through the stages
   always_comb
   begin
      nxt_state      = state_ff;
      nxt_state.meta = async_in;
      nxt_state.sync = state_ff.meta;
      nxt_state.prev = state_ff.sync;
   end

   // Clear all stages under reset
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign level = state_ff.sync;
   assign rise  = state_ff.sync & ~state_ff.prev;

endmodule

/* core/nfc_ahb_slave.sv */
// AHB-Lite slave front end: one wait state on reads, none on writes
module nfc_ahb_slave
   import nfc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   output logic [31:0]      hrdata,
   output nfc_regreq_t      reg_req,
   input  wire logic [31:0] rd_data
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      nfc_bus_st_t           st;      // Transfer phase
      logic [NFC_ADDR_W-1:0] addr;    // Captured offset
      logic                  word;    // Captured size was a word
      logic [31:0]           rdata;   // Read data register
   } nfc_bus_state_t;

   nfc_bus_state_t state_ff;                                     // Registered state
   nfc_bus_state_t nxt_state;                                    // Next state
   logic           accept;                                       // Address phase taken

   // Address phase taken while the bus is ready
   assign accept = hsel & hready & htrans[1];

   // Phase sequencing and read capture
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff.st)
         NFC_BUS_RDW:
         begin
            // Wait cycle: capture read data after prior writes landed
            nxt_state.rdata = rd_data;
            nxt_state.st    = NFC_BUS_RDD;
         end
         default:
         begin
            // Idle, write data phase and read data phase may take a new request
            if (accept)
            begin
               nxt_state.addr = {haddr[NFC_ADDR_W-1:2], 2'b00};
               nxt_state.word = (hsize == NFC_HSIZE_WORD);
               nxt_state.st   = hwrite ? NFC_BUS_WR : NFC_BUS_RDW;
            end
            else
            begin
               nxt_state.st = NFC_BUS_IDLE;
            end
         end
      endcase
   end

   // Return to idle under reset
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_ff <= '{st: NFC_BUS_IDLE, addr: '0, word: 1'b0, rdata: '0};
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Outputs toward bus and register file
   assign hreadyout     = (state_ff.st != NFC_BUS_RDW);
   assign hresp         = NFC_HRESP_OKAY;
   assign hrdata        = state_ff.rdata;
   assign reg_req.wr    = (state_ff.st == NFC_BUS_WR) & state_ff.word;
   assign reg_req.rd    = (state_ff.st == NFC_BUS_RDW);
   assign reg_req.addr  = state_ff.addr;
   assign reg_req.wdata = hwdata;

endmodule

/* core/nfc_flash_ctrl.sv */
// Flash control bits: interrupt, program and erase permission, disable, standby, protect
// Contract
// R1: Writing one to bit 14 clears request
// R2: Enabled request on each completion rising edge
// R3: Bit 12 permits or blocks programming
// R4: Writing one to bit 11 starts erase
// R5: Software sets erase enable before start
// R6: Bit 10 permits or blocks sector erase
// R7: Bit 9 disables flash, outputs released
// R8: Bit 8 selects low power standby
// R9: Bit 7 refuses program/erase in bank
// R10: Request stays until cleared or reset
module nfc_flash_ctrl
   import nfc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   output logic [31:0]      hrdata,
   input  wire logic        operation_done_flag,
   input  wire logic        erase_in_protected,
   input  wire logic        prog_req,
   input  wire logic        prog_in_protected,
   output logic             prog_grant,
   output logic             prog_refused,
   output nfc_flash_out_t   flash_out
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      nfc_ctrl_t   ctrl;        // Control fields
      nfc_ers_st_t ers;         // Erase sequencer
      logic        irq_pend;    // Pending request
      logic        erase_go;    // Erase start pulse
      logic        erase_ref;   // Last erase start refused
      logic        prog_ref;    // Sticky program refusal
      logic        prog_gnt;    // Program grant pulse
      logic        prog_rfp;    // Program refusal pulse
   } nfc_top_state_t;

   nfc_top_state_t state_ff;    // Registered state
   nfc_top_state_t nxt_state;   // Next state
   nfc_regreq_t    reg_req;     // Register access
   logic [31:0]    rd_data;     // Read mux
   logic           done_lvl;    // Synced completion flag
   logic           done_rise;   // Completion rising edge
   logic           wr_ctrl;     // Control write strobe
   logic           wr_stat;     // Status write strobe
   logic           erase_ok;    // Erase start permitted
   logic           prog_ok;     // Program permitted

   // ************************************************************
   // Bus front end
   // ************************************************************
   nfc_ahb_slave u_bus (
      .core_clk  (core_clk),
      .reset     (reset),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .reg_req   (reg_req),
      .rd_data   (rd_data)
   );

   // ************************************************************
   // Completion flag from the array side
   // ************************************************************
   nfc_sync_rise u_done (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in (operation_done_flag),
      .level    (done_lvl),
      .rise     (done_rise)
   );

   // Write strobes per register
   assign wr_ctrl = reg_req.wr & (reg_req.addr == NFC_CTRL_OFS);
   assign wr_stat = reg_req.wr & (reg_req.addr == NFC_STAT_OFS);

   // Erase may start only from the fields already held before the write
   assign erase_ok = state_ff.ctrl.erase_enable                      // R5 R6
                   & ~(state_ff.ctrl.protected_sector_bank & erase_in_protected) // R9
                   & ~state_ff.ctrl.flash_disable                    // R7
                   & (state_ff.ers == NFC_ERS_IDLE);

   // Programming permission per request
   assign prog_ok = state_ff.ctrl.program_enable                     // R3
                  & ~(state_ff.ctrl.protected_sector_bank & prog_in_protected) // R9
                  & ~state_ff.ctrl.flash_disable;                    // R7

   // ************************************************************
   // Read mux
   // ************************************************************
   always_comb
   begin
      rd_data = NFC_RD_ZERO;
      if (reg_req.addr == NFC_CTRL_OFS)
      begin
         // Write-one fields read as zero
         rd_data[NFC_IRQ_EN_BIT]  = state_ff.ctrl.irq_enable;
         rd_data[NFC_PROG_EN_BIT] = state_ff.ctrl.program_enable;
         rd_data[NFC_ERS_EN_BIT]  = state_ff.ctrl.erase_enable;
         rd_data[NFC_DIS_BIT]     = state_ff.ctrl.flash_disable;
         rd_data[NFC_STBY_BIT]    = state_ff.ctrl.standby_select;
         rd_data[NFC_PROT_BIT]    = state_ff.ctrl.protected_sector_bank;
      end
      else if (reg_req.addr == NFC_STAT_OFS)
      begin
         // Block state
         rd_data[NFC_ST_IRQ_BIT]  = state_ff.irq_pend;
         rd_data[NFC_ST_DONE_BIT] = done_lvl;
         rd_data[NFC_ST_BUSY_BIT] = (state_ff.ers == NFC_ERS_RUN);
         rd_data[NFC_ST_EREF_BIT] = state_ff.erase_ref;
         rd_data[NFC_ST_PREF_BIT] = state_ff.prog_ref;
      end
      else
      begin
         // Unmapped offsets read zero
         rd_data = NFC_RD_ZERO;
      end
   end

   // ************************************************************
   // Control, interrupt and erase sequencing
   // ************************************************************
   always_comb
   begin
      nxt_state          = state_ff;
      nxt_state.erase_go = 1'b0;
      nxt_state.prog_gnt = 1'b0;
      nxt_state.prog_rfp = 1'b0;

      // Control field update
      if (wr_ctrl)
      begin
         nxt_state.ctrl.irq_enable            = reg_req.wdata[NFC_IRQ_EN_BIT];
         nxt_state.ctrl.program_enable        = reg_req.wdata[NFC_PROG_EN_BIT];
         nxt_state.ctrl.erase_enable          = reg_req.wdata[NFC_ERS_EN_BIT];
         nxt_state.ctrl.flash_disable         = reg_req.wdata[NFC_DIS_BIT];
         nxt_state.ctrl.standby_select        = reg_req.wdata[NFC_STBY_BIT];
         nxt_state.ctrl.protected_sector_bank = reg_req.wdata[NFC_PROT_BIT];
      end

      // Pending request: a new edge wins over a clear in the same cycle
      if (state_ff.ctrl.irq_enable & done_rise)
      begin
         nxt_state.irq_pend = 1'b1;                                  // R2
      end
      else if (wr_ctrl & reg_req.wdata[NFC_IRQ_CLR_BIT])
      begin
         nxt_state.irq_pend = 1'b0;                                  // R1 R10
      end

      // Erase sequencer
      unique case (state_ff.ers)
         NFC_ERS_IDLE:
         begin
            // Writing zero to the start field does nothing
            if (wr_ctrl & reg_req.wdata[NFC_ERS_GO_BIT])
            begin
               if (erase_ok)
               begin
                  nxt_state.erase_go  = 1'b1;                        // R4
                  nxt_state.erase_ref = 1'b0;
                  nxt_state.ers       = NFC_ERS_RUN;
               end
               else
               begin
                  nxt_state.erase_ref = 1'b1;                        // R6
               end
            end
         end
         NFC_ERS_RUN:
         begin
            // Completion ends the erase; a start meanwhile is refused
            if (wr_ctrl & reg_req.wdata[NFC_ERS_GO_BIT])
            begin
               nxt_state.erase_ref = 1'b1;
            end
            if (done_rise)
            begin
               nxt_state.ers = NFC_ERS_IDLE;
            end
         end
         default:
         begin
            // Illegal code recovers to idle
            nxt_state.ers = NFC_ERS_IDLE;
         end
      endcase

      // Program requests from the array side
      if (prog_req)
      begin
         if (prog_ok)
         begin
            nxt_state.prog_gnt = 1'b1;                               // R3
         end
         else
         begin
            nxt_state.prog_rfp = 1'b1;                               // R9
            nxt_state.prog_ref = 1'b1;
         end
      end
      else if (wr_stat & reg_req.wdata[NFC_ST_PREF_BIT])
      begin
         // Sticky refusal cleared by writing one; any program request in that cycle wins
         nxt_state.prog_ref = 1'b0;
      end
   end

   // Register all state
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_ff      <= '0;
         state_ff.ctrl <= nfc_ctrl_t'({NFC_CTRL_RST[NFC_IRQ_EN_BIT:NFC_PROG_EN_BIT],
                                       NFC_CTRL_RST[NFC_ERS_EN_BIT:NFC_PROT_BIT]});
         state_ff.ers  <= NFC_ERS_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ************************************************************
   // Outputs to the flash array
   // ************************************************************
   assign flash_out.program_allow = state_ff.ctrl.program_enable
                                  & ~state_ff.ctrl.flash_disable;    // R3
   assign flash_out.erase_go      = state_ff.erase_go;               // R4
   assign flash_out.pins_oe       = ~state_ff.ctrl.flash_disable;    // R7
   assign flash_out.standby       = state_ff.ctrl.standby_select;    // R8
   assign flash_out.irq           = state_ff.irq_pend;               // R10
   assign prog_grant              = state_ff.prog_gnt;
   assign prog_refused            = state_ff.prog_rfp;

endmodule

/* tb/nfc_monitor.sv */
// Checker of the flash control bits, watching the top ports only
module nfc_monitor
   import nfc_pkg::*;
(
   input wire logic           core_clk,
   input wire logic           reset,
   input wire logic           hsel,
   input wire logic [31:0]    haddr,
   input wire logic [1:0]     htrans,
   input wire logic           hwrite,
   input wire logic [2:0]     hsize,
   input wire logic           hready,
   input wire logic [31:0]    hwdata,
   input wire logic           hreadyout,
   input wire logic           operation_done_flag,
   input wire logic           prog_req,
   input wire logic           prog_in_protected,
   input wire logic           prog_grant,
   input wire logic           prog_refused,
   input wire nfc_flash_out_t flash_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        wr_ph_ff;                  // Control write in data phase
   logic [15:0] ctrl_ff;                   // Shadow of the control fields
   logic        pok;                       // Program would be permitted
   logic        go_ok;                     // Erase start allowed by the enable and disable fields
   assign pok   = ctrl_ff[12] && !ctrl_ff[9] && !(ctrl_ff[7] && prog_in_protected);
   assign go_ok = wr_ph_ff && hwdata[11] && ctrl_ff[10] && !ctrl_ff[9];
   // Shadow register follows word writes to the control offset
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wr_ph_ff <= 1'b0;
         ctrl_ff  <= 16'h0000;
      end
      else if (hready)
      begin
         wr_ph_ff <= hsel && htrans[1] && hwrite && (haddr[7:0] == NFC_CTRL_OFS)
                     && (hsize == NFC_HSIZE_WORD);
         ctrl_ff  <= wr_ph_ff ? hwdata[15:0] : ctrl_ff;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_rd; hsel && hready && htrans[1] && !hwrite; endsequence
   sequence s_clr; wr_ph_ff && hwdata[14]; endsequence
   property p_rd_wait; s_rd |=> !hreadyout ##1 hreadyout; endproperty
   property p_allow; flash_out.program_allow == (ctrl_ff[12] && !ctrl_ff[9]); endproperty
   property p_oe; flash_out.pins_oe == !ctrl_ff[9]; endproperty
   property p_stby; flash_out.standby == ctrl_ff[8]; endproperty
   property p_prog_ok; prog_req && pok |=> prog_grant && !prog_refused; endproperty
   property p_prog_no; prog_req && !pok |=> prog_refused && !prog_grant; endproperty
   property p_ers_go; flash_out.erase_go |-> $past(go_ok) ##1 !flash_out.erase_go; endproperty
   property p_irq_hold; flash_out.irq && !(wr_ph_ff && hwdata[14]) |=> flash_out.irq; endproperty
   property p_irq_clr; (!$rose(operation_done_flag))[*4] ##0 s_clr |=> !flash_out.irq; endproperty
   property p_irq_up; $rose(operation_done_flag) && ctrl_ff[13] |-> ##[2:5] flash_out.irq; endproperty
   property p_irq_quiet; $rose(flash_out.irq) |-> $past(ctrl_ff[13]); endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   a_allow: assert property (p_allow) else $error("program allow wrong");
   a_oe: assert property (p_oe) else $error("pin drive wrong");
   a_stby: assert property (p_stby) else $error("standby wrong");
   a_prog_ok: assert property (p_prog_ok) else $error("program not granted");
   a_prog_no: assert property (p_prog_no) else $error("program not refused");
   a_ers_go: assert property (p_ers_go) else $error("erase start wrong");
   a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
   a_irq_clr: assert property (p_irq_clr) else $error("request not cleared");
   a_irq_up: assert property (p_irq_up) else $error("request not raised");
   a_irq_quiet: assert property (p_irq_quiet) else $error("request while disabled");
endmodule

bind nfc_flash_ctrl nfc_monitor u_mon (.core_clk(core_clk), .reset(reset), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hwdata(hwdata), .hreadyout(hreadyout), .operation_done_flag(operation_done_flag),
   .prog_req(prog_req), .prog_in_protected(prog_in_protected), .prog_grant(prog_grant),
   .prog_refused(prog_refused), .flash_out(flash_out));

/* tb/nfc_flash_model.sv */
// Behavioural flash array: completion flag drops on a start, rises after a delay
module nfc_flash_model
(
   input  wire logic       core_clk,
   input  wire logic       start,
   input  wire logic [7:0] lat,
   output logic            operation_done_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_ff;                     // Remaining busy cycles
   initial
   begin
      operation_done_flag = 1'b0;
      cnt_ff = 8'h00;
   end
   // Flag rises off the clock edge, as an unsynchronised level would
   always @(posedge core_clk)
   begin
      if (start)
      begin
         operation_done_flag <= 1'b0;
         cnt_ff <= lat;
      end
      else if (cnt_ff != 8'h00)
      begin
         cnt_ff <= cnt_ff - 8'h01;
         if (cnt_ff == 8'h01)
            operation_done_flag <= #7 1'b1;
      end
   end
endmodule

/* tb/tb.sv */
// Self-checking bench of the flash control block
module tb;
   import nfc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic           core_clk, reset, hsel, hwrite, hreadyout, done, ers_prot, rdp;
   logic           prog_req, prog_prot, prog_grant, prog_refused;
   logic [1:0]     htrans, hresp;
   logic [2:0]     hsize;
   logic [31:0]    haddr, hwdata, hrdata, rv;
   logic [7:0]     lat;
   logic [15:0]    c;
   nfc_flash_out_t fo;
   int             mismatches, cmp_count, ers_cnt, seed, i;
   logic [31:0]    rdq[$];                 // Expected read data
   logic [1:0]     pgq[$];                 // Expected grant and refusal
   nfc_flash_ctrl DUT (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .operation_done_flag(done),
      .erase_in_protected(ers_prot), .prog_req(prog_req), .prog_in_protected(prog_prot),
      .prog_grant(prog_grant), .prog_refused(prog_refused), .flash_out(fo));
   nfc_flash_model u_flash (.core_clk(core_clk), .start(fo.erase_go), .lat(lat),
      .operation_done_flag(done));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Ready is read between edges, so it is the value that the next edge samples
   task automatic wait_rdy;
      logic r;
      do
      begin
         @(negedge core_clk);
         r = hreadyout;
         @(posedge core_clk);
      end while (r !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdq.push_back(e);
      bus(1'b0, a, 32'h00000000);
   endtask
   task automatic prog(input logic p, input logic [1:0] e);
      pgq.push_back(e);
      @(posedge core_clk);
      prog_req <= 1'b1;
      prog_prot <= p;
      @(posedge core_clk);
      prog_req <= 1'b0;
   endtask
   task automatic chk_fo(input nfc_flash_out_t e);
      @(negedge core_clk);
      check({27'h0, fo}, {27'h0, e});
   endtask
   task automatic wait_done;
      for (i = 0; i < 60 && done !== 1'b0; i++)
         @(posedge core_clk);
      for (i = 0; i < 60 && done !== 1'b1; i++)
         @(posedge core_clk);
      repeat (5) @(posedge core_clk);
   endtask
   // Watcher takes the oldest note whenever a result appears
   always @(negedge core_clk)
   begin
      if (rdp && hreadyout)
      begin
         check(hrdata, rdq.pop_front());
         rdp = 1'b0;
      end
      if (hsel && hreadyout && htrans[1] && !hwrite)
         rdp = 1'b1;
      if (prog_grant || prog_refused)
         check({30'h0, prog_grant, prog_refused}, {30'h0, pgq.pop_front()});
      if (fo.erase_go)
         ers_cnt++;
   end
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial
   begin
      #1000000;
      mismatches++;
      wrap_up();
   end
   initial
   begin
      {reset, hsel, hwrite, ers_prot, prog_req, prog_prot, rdp} = 7'h40;
      {htrans, haddr, hwdata, hsize, lat} = {2'h0, 64'h0, NFC_HSIZE_WORD, 8'h14};
      {mismatches, cmp_count, ers_cnt, seed} = {96'h0, 32'h17D0};
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      chk_fo(5'h04);
      rd(NFC_CTRL_OFS, 32'h0);
      wr(8'h08, 32'hFFFF);
      rd(8'h08, 32'h0);
      $display("test reset done");
      repeat (8)
      begin
         rv = $random(seed);
         c = rv[15:0] & 16'hB7FF;
         wr(NFC_CTRL_OFS, {rv[31:16], c});
         rd(NFC_CTRL_OFS, {16'h0, c & 16'h3780});
         chk_fo({c[12] & !c[9], 1'b0, !c[9], c[8], 1'b0});
         prog(rv[20], (c[12] & !c[9] & !(c[7] & rv[20])) ? 2'h2 : 2'h1);
      end
      wr(NFC_CTRL_OFS, 32'h1080);
      prog(1'b1, 2'h1);
      prog(1'b0, 2'h2);
      $display("test fields done");
      wr(NFC_STAT_OFS, 32'h10);
      wr(NFC_CTRL_OFS, 32'h0C00);
      rd(NFC_STAT_OFS, 32'h8);
      wr(NFC_CTRL_OFS, 32'h0C00);
      rd(NFC_STAT_OFS, 32'h4);
      check(32'(ers_cnt), 32'h1);
      wait_done();
      rd(NFC_STAT_OFS, 32'h2);
      chk_fo(5'h04);
      wr(NFC_CTRL_OFS, 32'h0);
      wr(NFC_CTRL_OFS, 32'h0800);
      ers_prot <= 1'b1;
      wr(NFC_CTRL_OFS, 32'h0480);
      wr(NFC_CTRL_OFS, 32'h0C80);
      ers_prot <= 1'b0;
      wr(NFC_CTRL_OFS, 32'h0600);
      wr(NFC_CTRL_OFS, 32'h0E00);
      check(32'(ers_cnt), 32'h1);
      $display("test erase done");
      lat <= 8'h03;
      wr(NFC_CTRL_OFS, 32'h2400);
      wr(NFC_CTRL_OFS, 32'h2C00);
      wait_done();
      chk_fo(5'h05);
      wr(NFC_CTRL_OFS, 32'h2400);
      chk_fo(5'h05);
      wr(NFC_CTRL_OFS, 32'h6400);
      chk_fo(5'h04);
      $display("test interrupt done");
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(NFC_CTRL_OFS, 32'h0);
      chk_fo(5'h04);
      $display("test second reset done");
      wrap_up();
   end
endmodule
